// file: core/rfc_pkg.sv
// Package of constants for the radio control configuration slice
`default_nettype none
package rfc_pkg;
	// ==========================================================
	// Register map
	localparam logic [5:0] RADIO_FSM_CONFIG0_ADDR = 6'h18;
	localparam logic [7:0] RADIO_FSM_CONFIG0_RST  = 8'h04;
	// ==========================================================
	// Field positions
	localparam int AUTOCAL_LSB   = 4;
	localparam int SETTLE_LSB    = 2;
	localparam int PIN_CTRL_BIT  = 1;
	localparam int OSC_KEEP_BIT  = 0;
	// ==========================================================
	// Autocal settings
	localparam logic [1:0] AUTOCAL_NEVER     = 2'h0;
	localparam logic [1:0] AUTOCAL_FROM_IDLE = 2'h1;
	localparam logic [1:0] AUTOCAL_TO_IDLE   = 2'h2;
	localparam logic [1:0] AUTOCAL_EVERY4    = 2'h3;
	// ==========================================================
	// Ripple counter and expiry counts
	localparam int         RIPPLE_BITS  = 6;
	localparam logic [8:0] EXPIRE_CNT0  = 9'h001;
	localparam logic [8:0] EXPIRE_CNT1  = 9'h010;
	localparam logic [8:0] EXPIRE_CNT2  = 9'h040;
	localparam logic [8:0] EXPIRE_CNT3  = 9'h100;
	// ==========================================================
	// Radio states seen by this slice
	typedef enum logic [4:0] {
		RFC_SLEEP = 5'h01,
		RFC_IDLE  = 5'h02,
		RFC_RX    = 5'h04,
		RFC_TX    = 5'h08,
		RFC_FSTX  = 5'h10
	} rfc_state_e;
endpackage
`default_nettype wire

// file: core/rfc_settle_timer.sv
// Six-bit ripple counter that counts expiries after the oscillator settles
`default_nettype none
module rfc_settle_timer
	import rfc_pkg::*;
#(
	parameter int RBITS = RIPPLE_BITS
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [1:0] settle_sel,
	output logic            done
);
	logic [RBITS-1:0] ripple_reg;
	logic [8:0]       expiry_reg;
	logic [8:0]       target;

	// Expiry count chosen by the field
	always_comb begin
		case (settle_sel)
			2'h0:    target = EXPIRE_CNT0; // R6
			2'h1:    target = EXPIRE_CNT1; // R6
			2'h2:    target = EXPIRE_CNT2; // R6
			default: target = EXPIRE_CNT3; // R6
		endcase
	end

	// Count ripple wraps while running; clear when stopped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ripple_reg <= '0;
			expiry_reg <= 9'h000;
			done       <= 1'b0;
		end else if (!run) begin
			ripple_reg <= '0;
			expiry_reg <= 9'h000;
			done       <= 1'b0;
		end else if (!done) begin
			ripple_reg <= ripple_reg + 1'b1;
			if (&ripple_reg) begin
				expiry_reg <= expiry_reg + 9'h001;
				if (expiry_reg + 9'h001 >= target)
					done <= 1'b1; // R5
			end
		end
	end
endmodule
`default_nettype wire

// file: core/rfc_fsm_config.sv
// Radio state machine configuration register with calibration and ready timing
// Notes on behaviour
// R1 - With autocal setting 00 calibration starts only from the calibrate strobe.
// R2 - With setting 01 calibration runs on each move from idle to receive, transmit or transmit-synth-on.
// R3 - With setting 10 calibration runs on each return from receive or transmit to idle.
// R4 - With setting 11 calibration runs on every fourth such return, using a modulo-four count.
// R5 - After the oscillator settles, chip ready goes low only once the ripple counter expired enough times.
// R6 - The two-bit settle field picks 1, 16, 64 or 256 expiries and resets to 01.
// R7 - The pin control enable bit lets pins steer radio state and resets to off.
// R8 - The keep-on bit holds the oscillator running in sleep.
`default_nettype none
module rfc_fsm_config
	import rfc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       cfg_wr,
	input  wire logic       cfg_rd,
	input  wire logic [5:0] cfg_addr,
	input  wire logic [7:0] cfg_wdata,
	output logic      [7:0] cfg_rdata,
	input  wire logic       calibrate_strobe,
	input  wire logic [4:0] radio_state,
	input  wire logic       osc_stable_pin,
	output logic            synth_cal_start,
	output logic            chip_ready_n,
	output logic            pin_ctrl_enable,
	output logic            osc_keep_on_in_sleep
);
	// ==========================================================
	// Decoding helpers
	// Each decode is shared by every place that needs it, so the write
	// path, the read path and the transition logic cannot drift apart.

	// True when the port addresses the one mapped register
	function automatic logic cfg_hit(input logic [5:0] addr);
		cfg_hit = addr == RADIO_FSM_CONFIG0_ADDR;
	endfunction

	// True for the two states whose exit to idle counts as a return
	function automatic logic is_rx_or_tx(input logic [4:0] state);
		is_rx_or_tx = state == RFC_RX || state == RFC_TX;
	endfunction

	// True for the states an idle-to-active calibration may target
	function automatic logic is_active_target(input logic [4:0] state);
		is_active_target = is_rx_or_tx(state) || state == RFC_FSTX;
	endfunction

	// Byte layout seen by the host; bits 7:6 are not implemented
	function automatic logic [7:0] pack_cfg(
		input logic [1:0] autocal,
		input logic [1:0] settle,
		input logic       pin_ctrl,
		input logic       osc_keep
	);
		pack_cfg = {2'h0, autocal, settle, pin_ctrl, osc_keep};
	endfunction

	// ==========================================================
	// Configuration register
	// Field map of the byte:
	//   7:6 unused, read as zero
	//   5:4 autocal select, when the synthesizer calibrates itself
	//   3:2 settle count select, ripple expiries before ready
	//   1   pin control enable
	//   0   keep oscillator on in sleep
	logic [1:0] synth_autocal_select_reg;
	logic [1:0] poweron_settle_count_reg;
	logic       pin_ctrl_reg;
	logic       osc_keep_reg;
	logic       cfg_wr_hit;
	logic       cfg_rd_hit;

	// Strobes qualified by the address; writes to other addresses are ignored, reads of them return zero
	assign cfg_wr_hit = cfg_wr && cfg_hit(cfg_addr);
	assign cfg_rd_hit = cfg_rd && cfg_hit(cfg_addr);

	// Autocal select field
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			synth_autocal_select_reg <= RADIO_FSM_CONFIG0_RST[AUTOCAL_LSB+:2];
		else if (cfg_wr_hit)
			synth_autocal_select_reg <= cfg_wdata[AUTOCAL_LSB+:2];
	end

	// Settle count field; a change mid-count takes effect at the next expiry
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			poweron_settle_count_reg <= RADIO_FSM_CONFIG0_RST[SETTLE_LSB+:2]; // R6
		else if (cfg_wr_hit)
			poweron_settle_count_reg <= cfg_wdata[SETTLE_LSB+:2];
	end

	// Pin control enable bit, off after reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			pin_ctrl_reg <= RADIO_FSM_CONFIG0_RST[PIN_CTRL_BIT]; // R7
		else if (cfg_wr_hit)
			pin_ctrl_reg <= cfg_wdata[PIN_CTRL_BIT];
	end

	// Oscillator keep-on bit
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			osc_keep_reg <= RADIO_FSM_CONFIG0_RST[OSC_KEEP_BIT];
		else if (cfg_wr_hit)
			osc_keep_reg <= cfg_wdata[OSC_KEEP_BIT]; // R8
	end

	// Read data registered; unmapped addresses read zero and the
	// last read value stands until the next read strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			cfg_rdata <= 8'h00;
		else if (cfg_rd_hit)
			cfg_rdata <= pack_cfg(synth_autocal_select_reg, poweron_settle_count_reg, pin_ctrl_reg, osc_keep_reg);
		else if (cfg_rd)
			cfg_rdata <= 8'h00;
	end

	// Pin control goes out through its own flop so the output is glitch free
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			pin_ctrl_enable <= RADIO_FSM_CONFIG0_RST[PIN_CTRL_BIT];
		else
			pin_ctrl_enable <= pin_ctrl_reg; // R7
	end

	// Keep-on request for the oscillator power control, one cycle behind the bit
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			osc_keep_on_in_sleep <= RADIO_FSM_CONFIG0_RST[OSC_KEEP_BIT];
		else
			osc_keep_on_in_sleep <= osc_keep_reg; // R8
	end

	// ==========================================================
	// Transition detection; a state change is seen in the same cycle, against the registered previous state
	logic [4:0] prev_state_reg;
	logic       from_idle;
	logic       to_idle;

	// Previous state, reset to idle so the first cycle shows no move
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			prev_state_reg <= RFC_IDLE;
		else
			prev_state_reg <= radio_state;
	end

	// Leaving idle for an active state; a wake from sleep straight into
	// receive is not a move from idle and does not calibrate
	assign from_idle = prev_state_reg == RFC_IDLE && is_active_target(radio_state); // R2
	// Returning to idle; leaving the transmit-synth-on state is not a return
	assign to_idle   = is_rx_or_tx(prev_state_reg) && radio_state == RFC_IDLE; // R3

	// Modulo-four count of returns to idle, kept in every mode
	// so switching into setting 11 keeps the phase of earlier returns
	logic [1:0] return_cnt_reg;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			return_cnt_reg <= 2'h0;
		else if (to_idle)
			return_cnt_reg <= return_cnt_reg + 2'h1; // R4
	end

	// Calibration request: one-cycle pulse. A strobe and an automatic
	// event in the same cycle merge into one pulse, never two.
	logic cal_next;
	always_comb begin
		cal_next = calibrate_strobe; // R1
		case (synth_autocal_select_reg)
			AUTOCAL_NEVER:     cal_next = calibrate_strobe; // R1
			AUTOCAL_FROM_IDLE: cal_next = calibrate_strobe | from_idle; // R2
			AUTOCAL_TO_IDLE:   cal_next = calibrate_strobe | to_idle; // R3
			AUTOCAL_EVERY4:    cal_next = calibrate_strobe | (to_idle && return_cnt_reg == 2'h3); // R4
			default:           cal_next = calibrate_strobe;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			synth_cal_start <= 1'b0;
		else
			synth_cal_start <= cal_next;
	end

	// ==========================================================
	// Oscillator-stable pin synchroniser, then settle timer
	logic sync1_reg;
	logic sync2_reg;
	logic settle_done;

	// Two-flop synchroniser; only the second stage is read by logic
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= osc_stable_pin;
			sync2_reg <= sync1_reg;
		end
	end

	// Expiry counting lives in its own module; it restarts from zero
	// whenever the synchronised oscillator-stable level drops
	rfc_settle_timer rfc_settle_timer_inst (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.run        (sync2_reg),
		.settle_sel (poweron_settle_count_reg),
		.done       (settle_done)
	);

	// Ready is active low; released high again if the oscillator drops
	// The host must wait for the level, not an edge, after every wake
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			chip_ready_n <= 1'b1;
		else
			chip_ready_n <= ~settle_done; // R5
	end
endmodule
`default_nettype wire

// file: test/rfc_props.sv
// Port-level checks for the radio control configuration slice
`default_nettype none
module rfc_props
	import rfc_pkg::*;
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       cfg_wr,
	input wire logic [5:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic       calibrate_strobe,
	input wire logic [4:0] radio_state,
	input wire logic       osc_stable_pin,
	input wire logic       synth_cal_start,
	input wire logic       chip_ready_n,
	input wire logic       pin_ctrl_enable,
	input wire logic       osc_keep_on_in_sleep
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Write that lands in the one mapped register
	wire logic wr_hit = cfg_wr && cfg_addr == RADIO_FSM_CONFIG0_ADDR;
	a_keep_follow: assert property (wr_hit |-> ##2 osc_keep_on_in_sleep == $past(cfg_wdata[OSC_KEEP_BIT], 2))
		else $error("keep bit");
	a_pin_follow: assert property (wr_hit |-> ##2 pin_ctrl_enable == $past(cfg_wdata[PIN_CTRL_BIT], 2))
		else $error("pin bit");
	a_strobe_cal: assert property (calibrate_strobe |=> synth_cal_start) else $error("no manual cal");
	a_rxtx_quiet: assert property (radio_state == RFC_TX && $past(radio_state) == RFC_RX && !calibrate_strobe
		|=> !synth_cal_start) else $error("cal on rx to tx");
	a_pulse_single: assert property (synth_cal_start && !calibrate_strobe && $stable(radio_state)
		|=> !synth_cal_start) else $error("cal pulse long");
	a_ready_drop: assert property ($fell(osc_stable_pin) |-> ##[1:6] chip_ready_n) else $error("ready stuck");
	a_ready_late: assert property ($fell(chip_ready_n) |-> $past(osc_stable_pin, 8)) else $error("ready early");
	a_ready_wait: assert property ($rose(osc_stable_pin) |=> chip_ready_n [*8]) else $error("no wait");
endmodule
bind rfc_fsm_config rfc_props rfc_props_inst (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .calibrate_strobe(calibrate_strobe),
	.radio_state(radio_state), .osc_stable_pin(osc_stable_pin), .synth_cal_start(synth_cal_start),
	.chip_ready_n(chip_ready_n), .pin_ctrl_enable(pin_ctrl_enable), .osc_keep_on_in_sleep(osc_keep_on_in_sleep));
`default_nettype wire

// file: test/rfc_host.sv
// Host model driving the configuration port
`default_nettype none
module rfc_host (
	input  wire logic       clk,
	output logic            cfg_wr,
	output logic            cfg_rd,
	output logic      [5:0] cfg_addr,
	output logic      [7:0] cfg_wdata,
	input  wire logic [7:0] cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle port at time zero
	initial begin
		cfg_wr = 0;
		cfg_rd = 0;
		cfg_addr = 0;
		cfg_wdata = 0;
	end
	// One access; released data shows its inverse so stale values are never trusted
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk) #1;
		cfg_wr = w;
		cfg_rd = !w;
		cfg_addr = a;
		cfg_wdata = d;
		@(posedge clk) #1;
		cfg_wr = 0;
		cfg_rd = 0;
		cfg_wdata = ~d;
		q = cfg_rdata;
	endtask
endmodule
`default_nettype wire

// file: test/test_radio_ctrl_fsm_config.sv
// Self-checking bench for the radio control configuration slice
`default_nettype none
module test_radio_ctrl_fsm_config import rfc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic            clk, sys_rst, calibrate_strobe, osc_stable_pin;
	logic      [4:0] radio_state;
	logic      [7:0] q;
	wire logic       cfg_wr, cfg_rd, synth_cal_start, chip_ready_n, pin_ctrl_enable, osc_keep_on_in_sleep;
	wire logic [5:0] cfg_addr;
	wire logic [7:0] cfg_wdata, cfg_rdata;
	int              n_mismatch, samples_checked, n_cal;
	rfc_fsm_config rfc_fsm_config_inst (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .calibrate_strobe(calibrate_strobe),
		.radio_state(radio_state), .osc_stable_pin(osc_stable_pin), .synth_cal_start(synth_cal_start),
		.chip_ready_n(chip_ready_n), .pin_ctrl_enable(pin_ctrl_enable), .osc_keep_on_in_sleep(osc_keep_on_in_sleep));
	rfc_host rfc_host_inst (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
	// ==========================================
	// Clock and calibration pulse counter
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (synth_cal_start === 1'b1) n_cal++;
	// ==========================================
	// Helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want) begin
			n_mismatch++;
			$display("FAIL t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		rfc_host_inst.acc(1'b0, a, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask
	task automatic go(input logic [4:0] s);
		radio_state = s;
		step(3);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reg;
		rd(6'h18, 8'h04);
		chk({14'h0, pin_ctrl_enable, osc_keep_on_in_sleep}, 16'h0000);
		rfc_host_inst.acc(1'b1, 6'h18, 8'hff, q);
		rd(6'h18, 8'h3f);
		chk({14'h0, pin_ctrl_enable, osc_keep_on_in_sleep}, 16'h0003);
		rfc_host_inst.acc(1'b1, 6'h19, 8'h00, q);
		rd(6'h19, 8'h00);
		rd(6'h18, 8'h3f);
		$display("test reg done");
	endtask
	// Four modes; the return count keeps running so mode 3 sees the sixteenth return
	task automatic t_cal;
		logic [3:0] want [4] = '{4'h1, 4'h8, 4'h4, 4'h1};
		int         base;
		for (int m = 0; m < 4; m++) begin
			rfc_host_inst.acc(1'b1, 6'h18, 8'(m << AUTOCAL_LSB), q);
			step(3);
			base = n_cal;
			calibrate_strobe = (m == 0);
			step(1);
			calibrate_strobe = 0;
			repeat (4) begin
				go(RFC_RX);
				go(RFC_TX);
				go(RFC_IDLE);
				go(RFC_FSTX);
				go(RFC_IDLE);
			end
			chk(16'(n_cal - base), 16'(want[m]));
		end
		$display("test cal done");
	endtask
	task automatic t_ready;
		int cyc;
		int n [4] = '{1, 16, 64, 256};
		for (int s = 0; s < 4; s++) begin
			rfc_host_inst.acc(1'b1, 6'h18, 8'(s << SETTLE_LSB), q);
			osc_stable_pin = 1;
			cyc = 0;
			while (chip_ready_n !== 1'b0 && cyc < 20000) begin
				step(1);
				cyc++;
			end
			chk(16'(cyc / 64), 16'(n[s]));
			if (cyc >= 20000) begin
				n_mismatch++;
				finish_test;
			end
			osc_stable_pin = 0;
			step(8);
			chk({15'h0, chip_ready_n}, 16'h0001);
		end
		$display("test ready done");
	endtask
	// ==========================================
	// Main sequence
	initial begin
		sys_rst = 1;
		calibrate_strobe = 0;
		osc_stable_pin = 0;
		radio_state = RFC_IDLE;
		step(2);
		sys_rst = 0;
		t_reg;
		t_cal;
		t_ready;
		finish_test;
	end
endmodule
`default_nettype wire
